/* shared/sar_adc_pkg.sv */
// Shared constants, types and field layout of the converter sequencer
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR        = 8'h00;
  localparam logic [7:0] STATUS_ADDR      = 8'h04;
  localparam logic [7:0] RESULT_BASE_ADDR = 8'h20;
  localparam logic [7:0] RESULT_LAST_ADDR = 8'h3c;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_MODE_LSB   = 1;
  localparam int CTRL_CHAN_LSB   = 4;
  localparam int CTRL_SWEEP_LSB  = 7;
  localparam int CTRL_FREQ0_BIT  = 9;
  localparam int CTRL_FREQ1_BIT  = 10;
  localparam int CTRL_RES10_BIT  = 11;
  localparam int CTRL_SH_BIT     = 12;
  localparam int CTRL_GROUP_BIT  = 13;
  localparam int CTRL_VREF_BIT   = 14;
  localparam int CTRL_WEIGHT_BIT = 15;

  // Status register field positions
  localparam int STAT_REQ_BIT  = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_CHAN_LSB = 2;

  // ----------------------------------------------------------------
  // Conversion timing, in conversion-clock cycles
  // ----------------------------------------------------------------
  localparam logic [5:0] LEN_SH_10    = 6'd33;
  localparam logic [5:0] LEN_SH_8     = 6'd28;
  localparam logic [5:0] LEN_NOSH_10  = 6'd59;
  localparam logic [5:0] LEN_NOSH_8   = 6'd49;
  localparam logic [5:0] SAMPLE_TICKS = 6'd3;
  localparam logic [5:0] STEP_SH      = 6'd3;
  localparam logic [5:0] STEP_NOSH    = 6'd5;

  // Reset value of the control word and first trial value of the approximation register
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [9:0]  SAR_FIRST  = 10'h200;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ONE_SHOT = 3'h0,
    MODE_REPEAT   = 3'h1,
    MODE_SWEEP    = 3'h2,
    MODE_RSWEEP0  = 3'h3,
    MODE_RSWEEP1  = 3'h4
  } adc_mode_t;

  typedef struct packed {
    logic       weight_two;
    logic       vref_conn;
    logic       group_alt;
    logic       sh_en;
    logic       res10;
    logic       freq1;
    logic       freq0;
    logic [1:0] sweep_sel;
    logic [2:0] chan;
    logic [2:0] mode;
    logic       start;
  } adc_cfg_t;

  typedef struct packed {
    logic       we;
    logic [2:0] addr;
    logic [9:0] data;
  } result_wr_t;

endpackage

/* rtl/sar_result_mem.sv */
// Eight-word result store with a registered read port
module sar_result_mem
  import sar_adc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire result_wr_t i_wr,
  input  wire logic [2:0] i_rd_addr,
  output logic [9:0]      o_rd_data
);

  logic [9:0] mem_q [8];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset on the array; results are undefined until first converted
  always_ff @(posedge i_sys_clk) begin
    if (i_wr.we) begin
      mem_q[i_wr.addr] <= i_wr.data;
    end
  end

  // Registered read port
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 10'h000;
    end else begin
      o_rd_data <= mem_q[i_rd_addr];
    end
  end

endmodule // sar_result_mem

/* rtl/sar_adc_sequencer.sv */
// Successive-approximation converter sequencer with APB register access
//
// Notes on behaviour
// RQ1: One-shot mode converts one selected input once, then stops.
// RQ2: Repeat mode converts one selected input continuously.
// RQ3: Single sweep converts each selected input once in order, then stops.
// RQ4: Repeated sweep 0 converts the input set, restarting the sweep forever.
// RQ5: Repeated sweep 1 converts weighted inputs more often within the sweep.
// RQ6: Conversion clock is source clock divided by 1, 2 or 4.
// RQ7: Source clock equals the main system clock.
// RQ8: Upper select bit picks undivided; else lower bit picks /2, zero picks /4.
// RQ9: With sample-and-hold, 33 cycles at 10 bits, 28 at 8 bits.
// RQ10: Without sample-and-hold, 59 cycles at 10 bits, 49 at 8 bits.
// RQ11: With sample-and-hold, input sampled for first 3 conversion cycles.
// RQ12: Software keeps conversion clock at 1 MHz or more with sample-and-hold.
// RQ13: Resolution select; 8-bit resolves the top eight approximation bits.
// RQ14: Group select routes inputs from primary or alternate five-pin group; the code indexes eight inputs per group.
// RQ15: Software waits 1 us after reconnecting the reference before starting.
// RQ16: Software sets analog pins as inputs before use.
// RQ17: Writing one to the start flag launches conversion.
// RQ18: One-shot end stores result, sets request flag, clears start.
// RQ19: Repeating modes run until start cleared, store results, no request.
// RQ20: Single sweep sets request and clears start after all inputs.
//
// Implementation choices: the address map and register access over APB.
module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // Analog core
  input  wire logic        i_cmp,
  output logic             o_sample,
  output logic [2:0]       o_chan,
  output logic             o_group_alt,
  output logic             o_vref_conn,
  output logic [9:0]       o_trial,
  output logic             o_busy,
  output logic             o_conv_req
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CONV = 3'b010,
    S_NEXT = 3'b100
  } seq_state_t;

  seq_state_t state_q;
  seq_state_t state_d;
  adc_cfg_t   cfg_q;
  logic       req_q;
  logic [1:0] div_q;
  logic       tick;
  logic [5:0] tick_cnt_q;
  logic [5:0] sub_q;
  logic [3:0] bit_q;
  logic [9:0] sar_q;
  logic [2:0] chan_q;
  logic [2:0] main_ptr_q;
  logic [2:0] wptr_q;
  logic       wpass_q;
  logic       hw_stop;
  logic       last_tick;
  logic       decide;
  result_wr_t wr;
  logic [9:0] mem_rd;
  logic [2:0] mem_rd_addr;
  logic       apb_first;
  logic       wr_ctrl;
  logic       wr_status;
  logic       addr_ok;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Total conversion length per input
  function automatic logic [5:0] conv_len(input logic sh, input logic res10);
    if (sh) begin
      conv_len = res10 ? LEN_SH_10 : LEN_SH_8;
    end else begin
      conv_len = res10 ? LEN_NOSH_10 : LEN_NOSH_8;
    end
  endfunction

  // Ticks spent on each approximation bit
  function automatic logic [5:0] bit_step(input logic sh);
    bit_step = sh ? STEP_SH : STEP_NOSH;
  endfunction

  // Ticks before the first bit step; the rest of the length
  function automatic logic [5:0] lead_len(input logic sh, input logic res10);
    logic [5:0] bits;
    bits = res10 ? 6'd10 : 6'd8;
    lead_len = conv_len(sh, res10) - 6'(bits * bit_step(sh));
  endfunction

  // Last channel index of a sweep: 2, 4, 6 or 8 inputs
  function automatic logic [2:0] sweep_last(input logic [1:0] sel);
    sweep_last = {sel, 1'b1};
  endfunction

  // ----------------------------------------------------------------
  // Conversion clock divider
  // ----------------------------------------------------------------
  // RQ7 source clock
  // The divider runs on the system clock itself, so no second domain exists
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 2'h0;
    end else if (state_q != S_CONV) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // RQ6 RQ8 divide select
  always_comb begin
    if (cfg_q.freq1) begin
      tick = 1'b1;
    end else if (cfg_q.freq0) begin
      tick = div_q[0];
    end else begin
      tick = (div_q == 2'h3);
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state on every access gives the result store time to answer
  assign apb_first = i_psel & i_penable & ~o_pready;
  assign wr_ctrl   = apb_first & i_pwrite & (i_paddr == CTRL_ADDR);
  assign wr_status = apb_first & i_pwrite & (i_paddr == STATUS_ADDR);
  assign addr_ok   = (i_paddr == CTRL_ADDR) | (i_paddr == STATUS_ADDR) |
                     ((i_paddr >= RESULT_BASE_ADDR) && (i_paddr <= RESULT_LAST_ADDR) &&
                      (i_paddr[1:0] == 2'h0));
  assign mem_rd_addr = i_paddr[4:2];

  // Read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    if (i_paddr == CTRL_ADDR) begin
      rd_word[15:0] = cfg_q;
    end else if (i_paddr == STATUS_ADDR) begin
      rd_word[STAT_REQ_BIT]                  = req_q;
      rd_word[STAT_BUSY_BIT]                 = (state_q != S_IDLE);
      rd_word[STAT_CHAN_LSB +: 3]            = chan_q;
    end else if (addr_ok) begin
      rd_word[9:0] = mem_rd;
    end
  end

  // Bus answer, registered
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= apb_first;
      o_pslverr <= apb_first & ~addr_ok;
      if (apb_first && !i_pwrite) begin
        o_prdata <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register and start flag
  // ----------------------------------------------------------------
  // RQ17 start by write
  // A software write wins over the hardware clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= adc_cfg_t'(CTRL_RESET);
    end else if (wr_ctrl) begin
      cfg_q <= adc_cfg_t'(i_pwdata[15:0]);
    end else if (hw_stop) begin
      cfg_q.start <= 1'b0;
    end
  end

  // RQ18 RQ20 request flag
  // Set wins over a software clear arriving in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q <= 1'b0;
    end else if (hw_stop) begin
      req_q <= 1'b1;
    end else if (wr_status && !i_pwdata[STAT_REQ_BIT]) begin
      req_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state machine
  // ----------------------------------------------------------------
  assign last_tick = tick && (tick_cnt_q == conv_len(cfg_q.sh_en, cfg_q.res10) - 6'd1);

  // Stop with request only for one-shot and single sweep
  always_comb begin
    hw_stop = 1'b0;
    if (state_q == S_NEXT && cfg_q.start) begin
      unique case (adc_mode_t'(cfg_q.mode))
        // RQ1 single conversion
        MODE_ONE_SHOT: hw_stop = 1'b1;
        // RQ3 single sweep end
        MODE_SWEEP:    hw_stop = (chan_q == sweep_last(cfg_q.sweep_sel));
        default:       hw_stop = 1'b0;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (cfg_q.start) state_d = S_CONV;
      S_CONV: begin
        if (!cfg_q.start) begin
          state_d = S_IDLE;
        end else if (last_tick) begin
          state_d = S_NEXT;
        end
      end
      S_NEXT: begin
        // RQ19 run until cleared
        if (!cfg_q.start || hw_stop) begin
          state_d = S_IDLE;
        end else begin
          state_d = S_CONV;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Channel selection per mode
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chan_q     <= 3'h0;
      main_ptr_q <= 3'h0;
      wptr_q     <= 3'h0;
      wpass_q    <= 1'b0;
    end else if (state_q == S_IDLE) begin
      // Sweeps always begin at input zero
      if (cfg_q.mode == MODE_ONE_SHOT || cfg_q.mode == MODE_REPEAT) begin
        chan_q <= cfg_q.chan;
      end else begin
        chan_q <= 3'h0;
      end
      main_ptr_q <= cfg_q.weight_two ? 3'h2 : 3'h1;
      wptr_q     <= 3'h0;
      wpass_q    <= 1'b1;
    end else if (state_q == S_NEXT) begin
      unique case (adc_mode_t'(cfg_q.mode))
        // RQ2 same input again
        MODE_ONE_SHOT, MODE_REPEAT: chan_q <= cfg_q.chan;
        // RQ3 RQ4 advance sweep
        MODE_SWEEP, MODE_RSWEEP0: begin
          if (chan_q == sweep_last(cfg_q.sweep_sel)) begin
            chan_q <= 3'h0;
          end else begin
            chan_q <= chan_q + 3'h1;
          end
        end
        // RQ5 weighted inputs between others
        MODE_RSWEEP1: begin
          if (wpass_q) begin
            chan_q     <= main_ptr_q;
            wpass_q    <= 1'b0;
            main_ptr_q <= (main_ptr_q == sweep_last(cfg_q.sweep_sel)) ?
                          (cfg_q.weight_two ? 3'h2 : 3'h1) : main_ptr_q + 3'h1;
          end else begin
            chan_q  <= (cfg_q.weight_two && wptr_q == 3'h0) ? 3'h1 : 3'h0;
            wptr_q  <= (cfg_q.weight_two && wptr_q == 3'h0) ? 3'h1 : 3'h0;
            wpass_q <= 1'b1;
          end
        end
        default: chan_q <= 3'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Approximation timing and register
  // ----------------------------------------------------------------
  // RQ9 RQ10 conversion length
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 6'h00;
      sub_q      <= 6'h00;
    end else if (state_q != S_CONV) begin
      tick_cnt_q <= 6'h00;
      sub_q      <= 6'h00;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + 6'h01;
      if (tick_cnt_q >= lead_len(cfg_q.sh_en, cfg_q.res10)) begin
        sub_q <= (sub_q == bit_step(cfg_q.sh_en) - 6'h01) ? 6'h00 : sub_q + 6'h01;
      end
    end
  end

  assign decide = tick && (tick_cnt_q >= lead_len(cfg_q.sh_en, cfg_q.res10)) &&
                  (sub_q == bit_step(cfg_q.sh_en) - 6'h01);

  // RQ13 resolve top bits
  // In 8-bit mode the two lowest bits are never tried and stay zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sar_q <= 10'h000;
      bit_q <= 4'h9;
    end else if (state_q != S_CONV) begin
      sar_q <= SAR_FIRST;
      bit_q <= 4'h9;
    end else if (decide) begin
      sar_q[bit_q] <= i_cmp;
      if (bit_q != 4'h0 && !(bit_q == 4'h2 && !cfg_q.res10)) begin
        sar_q[bit_q - 4'h1] <= 1'b1;
        bit_q               <= bit_q - 4'h1;
      end
    end
  end

  // RQ18 RQ19 store result
  always_comb begin
    wr.we   = last_tick && cfg_q.start && (state_q == S_CONV);
    wr.addr = chan_q;
    wr.data = sar_q;
    // The last bit is decided on the storing tick, so fold it in here
    if (decide) begin
      wr.data[bit_q] = i_cmp;
    end
    if (!cfg_q.res10) begin
      wr.data = {2'h0, wr.data[9:2]};
    end
  end

  sar_result_mem u_result_mem (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_wr      (wr),
    .i_rd_addr (mem_rd_addr),
    .o_rd_data (mem_rd)
  );

  // ----------------------------------------------------------------
  // Analog side outputs
  // ----------------------------------------------------------------
  // RQ11 sample window
  // Without hold the input is tracked for the whole conversion
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample <= 1'b0;
    end else if (state_d != S_CONV) begin
      o_sample <= 1'b0;
    end else if (!cfg_q.sh_en) begin
      o_sample <= 1'b1;
    end else if (state_q != S_CONV) begin
      o_sample <= 1'b1;
    end else if (tick && tick_cnt_q == SAMPLE_TICKS - 6'd1) begin
      o_sample <= 1'b0;
    end
  end

  // RQ14 input group routing
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_chan      <= 3'h0;
      o_group_alt <= 1'b0;
      o_vref_conn <= 1'b0;
      o_trial     <= 10'h000;
      o_busy      <= 1'b0;
      o_conv_req  <= 1'b0;
    end else begin
      o_chan      <= chan_q;
      o_group_alt <= cfg_q.group_alt;
      o_vref_conn <= cfg_q.vref_conn;
      o_trial     <= sar_q;
      o_busy      <= (state_q != S_IDLE);
      o_conv_req  <= req_q;
    end
  end

endmodule // sar_adc_sequencer

/* testbench/sar_adc_monitor.sv */
// Port checker for the converter sequencer, bound to its top module
module sar_adc_monitor
  import sar_adc_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        o_sample,
  input wire logic        o_group_alt,
  input wire logic        o_vref_conn,
  input wire logic        o_busy,
  input wire logic        o_conv_req
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----
  // Shadow control word
  // ----
  logic     ctrl_wr;
  logic     mapped;
  adc_cfg_t cfg_q;

  // Completed APB write to the control word
  assign ctrl_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == CTRL_ADDR;
  // Aligned words of the map only; anything else is refused
  assign mapped = i_paddr == CTRL_ADDR || i_paddr == STATUS_ADDR ||
    (i_paddr >= RESULT_BASE_ADDR && i_paddr <= RESULT_LAST_ADDR && i_paddr[1:0] == 2'b00);

  // Start bit is kept too but never used: hardware clears it unseen
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      cfg_q <= i_pwdata[15:0];
    end
  end

  // ----
  // Assertions
  // ----
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  ready_wait_a: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  err_map_a: assert property (o_pready |-> o_pslverr == !mapped)
    else $error("bus error flag wrong");
  read_zero_a: assert property (o_pready && !i_pwrite && !mapped |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  ref_follow_a: assert property (
    ctrl_wr |=> ##[0:1] o_vref_conn == cfg_q.vref_conn) else $error("reference switch wrong");
  group_route_a: assert property (
    o_busy && $past(o_busy) |-> o_group_alt == cfg_q.group_alt) else $error("group wrong");
  sample_len_a: assert property (
    $rose(o_sample) && cfg_q.sh_en && cfg_q.freq1 |-> o_sample[*3] ##1 !o_sample)
    else $error("sample window not three cycles");
  start_busy_a: assert property (
    ctrl_wr && i_pwdata[CTRL_START_BIT] && !o_busy |-> ##[1:2] o_busy)
    else $error("start did not launch");
  abort_idle_a: assert property (
    ctrl_wr && !i_pwdata[CTRL_START_BIT] |-> ##[1:3] !o_busy) else $error("stop ignored");
  repeat_quiet_a: assert property (
    cfg_q.mode inside {MODE_REPEAT, MODE_RSWEEP0, MODE_RSWEEP1} && !o_conv_req |=> !o_conv_req)
    else $error("request raised in repeating mode");
  req_stops_a: assert property ($rose(o_conv_req) |-> ##[0:2] !o_busy)
    else $error("still busy after request");
endmodule // sar_adc_monitor

bind sar_adc_sequencer sar_adc_monitor u_mon (.i_sys_clk, .i_rst_n, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .o_sample,
  .o_group_alt, .o_vref_conn, .o_busy, .o_conv_req);

/* testbench/analog_core_model.sv */
// Behavioural comparator and input pins facing the sequencer
module analog_core_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_sample,
  input  wire logic [2:0] i_chan,
  input  wire logic       i_group_alt,
  input  wire logic       i_vref_conn,
  input  wire logic [9:0] i_trial,
  output logic            o_cmp
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [9:0] held_q;
  logic       noise_q;

  // Fixed pin level per group and input, wraps in ten bits
  function automatic logic [9:0] level(input logic g, input logic [2:0] c);
    level = 10'h0c3 + 10'(c) * 10'h07b + (g ? 10'h1a1 : 10'h000);
  endfunction

  // track while sampling
  // Held value is converted once sampling ends
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held_q  <= 10'h000;
      noise_q <= 1'b0;
    end else begin
      noise_q <= ~noise_q;
      if (i_sample) begin
        held_q <= level(i_group_alt, i_chan);
      end
    end
  end

  // compare held level
  // A cut reference gives a toggling answer, not a kind one
  assign o_cmp = i_vref_conn ? (held_q >= i_trial) : noise_q;
endmodule // analog_core_model

/* testbench/sar_adc_sequencer_test.sv */
// Self-checking bench for the converter sequencer
module sar_adc_sequencer_test
  import sar_adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst_n, psel, penable, pwrite, cmp, err;
  logic        pready, pslverr, sample, galt, vref, busy, req;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  chan;
  logic [9:0]  trial;
  logic [2:0]  seen[$];
  int          errors, comparisons, n;
  // One-shot table: hold, resolution, clock select, length, divide
  logic        sh[7] = '{1, 1, 0, 0, 1, 1, 1};
  logic        r10[7] = '{1, 0, 1, 0, 1, 1, 0};
  logic [1:0]  fq[7] = '{0, 0, 0, 0, 1, 2, 3};
  int          ln[7] = '{33, 28, 59, 49, 33, 33, 28};
  int          dv[7] = '{4, 4, 4, 4, 2, 1, 1};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  sar_adc_sequencer dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_cmp(cmp),
    .o_sample(sample), .o_chan(chan), .o_group_alt(galt), .o_vref_conn(vref),
    .o_trial(trial), .o_busy(busy), .o_conv_req(req));

  analog_core_model u_core (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sample(sample),
    .i_chan(chan), .i_group_alt(galt), .i_vref_conn(vref), .i_trial(trial), .o_cmp(cmp));

  // ----
  // Helpers
  // ----
  function automatic logic [9:0] lvl(input logic g, input logic [2:0] c);
    lvl = 10'h0c3 + 10'(c) * 10'h07b + (g ? 10'h1a1 : 10'h000);
  endfunction

  // Control word; reference always connected
  function automatic logic [31:0] cw(input logic st, input logic [2:0] md, input logic [2:0] ch,
    input logic [1:0] sw, input logic [1:0] f, input logic r, input logic s, input logic g,
    input logic w);
    cw = {16'h0000, w, 1'b1, g, s, r, f, sw, ch, md, st};
  endfunction

  task automatic wrap_up();
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      errors++;
      $display("Error at %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
    end
  endtask

  // Setup, then access until ready; entered and left just after an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let an edge pass so a following call never drives psel twice in one step
    @(posedge clk);
    if (k >= 40) chk(32'h1, 32'h0);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Busy cycles until the request flag shows
  task automatic conv_wait(output int c);
    c = 0;
    for (int i = 0; i < 3000 && req !== 1'b1; i++) begin
      @(posedge clk);
      if (busy === 1'b1) c++;
    end
  endtask

  // ----
  // Tests
  // ----
  initial begin
    errors = 0;
    comparisons = 0;
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(CTRL_ADDR, 32'hffffffff, 32'h0);
    rdchk(STATUS_ADDR, 32'hffffffff, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, RESULT_BASE_ADDR + 8'h1c, 32'h3ff);
    chk({31'h0, busy}, 32'h0);
    // Result words are mapped, though their contents are unknown until converted
    apb(1'b0, RESULT_BASE_ADDR + 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h0);
    // Analog pins taken as inputs; reference settles 1 us before a start
    apb(1'b1, CTRL_ADDR, cw(0, 0, 0, 0, 0, 0, 0, 0, 0));
    repeat (100) @(posedge clk);
    chk({31'h0, vref}, 32'h1);
    // Every clock select, hold and resolution; all keep the clock over 1 MHz
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, CTRL_ADDR, cw(1, MODE_ONE_SHOT, 3'(i), 0, fq[i], r10[i], sh[i], 0, 0));
      conv_wait(n);
      chk_span(n, ln[i] * dv[i] - 1, ln[i] * dv[i] + 3);
      apb(1'b1, RESULT_BASE_ADDR + 8'(4 * i), 32'h3ff);
      rdchk(RESULT_BASE_ADDR + 8'(4 * i), '1, 32'(lvl(0, 3'(i))) >> (r10[i] ? 0 : 2));
      rdchk(STATUS_ADDR, 32'h3, 32'h1);
      rdchk(CTRL_ADDR, 32'h1, 32'h0);
      apb(1'b1, STATUS_ADDR, 32'h0);
      rdchk(STATUS_ADDR, 32'h1, 32'h0);
    end
    // Repeat on the alternate group, then stop it
    apb(1'b1, CTRL_ADDR, cw(1, MODE_REPEAT, 2, 0, 2'b10, 1, 1, 1, 0));
    repeat (200) @(posedge clk);
    chk({29'h0, galt, busy, req}, 32'h6);
    rdchk(RESULT_BASE_ADDR + 8'h08, '1, 32'(lvl(1, 2)));
    apb(1'b1, CTRL_ADDR, cw(0, MODE_REPEAT, 2, 0, 2'b10, 1, 1, 1, 0));
    repeat (4) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    // Single sweep over four inputs
    apb(1'b1, CTRL_ADDR, cw(1, MODE_SWEEP, 0, 1, 2'b10, 1, 1, 0, 0));
    conv_wait(n);
    chk_span(n, 4 * 33, 4 * 33 + 20);
    for (int i = 0; i < 4; i++) rdchk(RESULT_BASE_ADDR + 8'(4 * i), '1, 32'(lvl(0, 3'(i))));
    rdchk(CTRL_ADDR, 32'h1, 32'h0);
    rdchk(STATUS_ADDR, 32'h3, 32'h1);
    apb(1'b1, STATUS_ADDR, 32'h0);
    // Repeated sweep of two alternate inputs
    apb(1'b1, CTRL_ADDR, cw(1, MODE_RSWEEP0, 0, 0, 2'b10, 1, 1, 1, 0));
    repeat (300) @(posedge clk);
    chk({30'h0, busy, req}, 32'h2);
    for (int i = 0; i < 2; i++) rdchk(RESULT_BASE_ADDR + 8'(4 * i), '1, 32'(lvl(1, 3'(i))));
    apb(1'b1, CTRL_ADDR, cw(0, MODE_RSWEEP0, 0, 0, 2'b10, 1, 1, 1, 0));
    // Weighted sweep: input 0 between each other input
    apb(1'b1, CTRL_ADDR, cw(1, MODE_RSWEEP1, 0, 1, 2'b10, 0, 1, 0, 0));
    repeat (260) begin
      @(posedge clk);
      if (busy === 1'b1 && (seen.size() == 0 || seen[$] !== chan)) seen.push_back(chan);
    end
    apb(1'b1, CTRL_ADDR, cw(0, MODE_RSWEEP1, 0, 1, 2'b10, 0, 1, 0, 0));
    chk_span(seen.size(), 6, 20);
    for (int i = 0; i < 6 && i < seen.size(); i++) chk(32'(seen[i]), 32'(i % 2 ? (i + 1) / 2 : 0));
    wrap_up();
  end

  // Whole run is near 2100 cycles; cut a hang well after that
  initial begin
    #100us;
    errors++;
    wrap_up();
  end
endmodule // sar_adc_sequencer_test
